// ==== rtl/uil_consts.svh ====
// Purpose: Named offsets, codes and reset values for the interrupt ident and line format block.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes: Offsets are byte addresses; data sits in the low byte.
`ifndef UIL_CONSTS_SVH
`define UIL_CONSTS_SVH

`define UIL_OFS_DIV_LO 4'h0
`define UIL_OFS_DIV_HI 4'h4
`define UIL_OFS_IDENT 4'h8
`define UIL_OFS_LINE 4'hC

`define UIL_NSRC 7
`define UIL_SRC_LINE 0
`define UIL_SRC_RXDATA 1
`define UIL_SRC_TIMEOUT 2
`define UIL_SRC_THRE 3
`define UIL_SRC_MODEM 4
`define UIL_SRC_XOFF 5
`define UIL_SRC_FLOW 6

`define UIL_ID_LINE 6'h06
`define UIL_ID_RXDATA 6'h04
`define UIL_ID_TIMEOUT 6'h0C
`define UIL_ID_THRE 6'h02
`define UIL_ID_MODEM 6'h00
`define UIL_ID_XOFF 6'h10
`define UIL_ID_FLOW 6'h20
`define UIL_ID_NONE 6'h01

`define UIL_LINE_RST 8'h00
`define UIL_EFR_RST 8'h00
`define UIL_DIV_RST 16'h0000
`define UIL_EFR_ENH_BIT 4

`define UIL_WLEN_BASE 4'h5
`define UIL_WLEN_FIVE 2'h0
`define UIL_STOP_ONE 3'h2
`define UIL_STOP_ONE_HALF 3'h3
`define UIL_STOP_TWO 3'h4

`endif

// ==== rtl/uil_pkg.sv ====
// Purpose: Types shared by the interrupt ident and line format block.
// Assumes: Constants come from uil_consts.svh.
// Notes: Line format bits map one to one onto the register byte.
package uil_pkg;

    typedef struct packed {
        logic dlab;
        logic brk;
        logic stick;
        logic even;
        logic par_en;
        logic stop_long;
        logic [1:0] wlen;
    } uil_fmt_t;

    typedef struct packed {
        logic flow;
        logic xoff;
        logic modem;
        logic thre;
        logic timeout;
        logic rxdata;
        logic line;
    } uil_ev_t;

    typedef enum logic [7:0] {
        S_NONE = 8'h01,
        S_LINE = 8'h02,
        S_RXDATA = 8'h04,
        S_TIMEOUT = 8'h08,
        S_THRE = 8'h10,
        S_MODEM = 8'h20,
        S_XOFF = 8'h40,
        S_FLOW = 8'h80
    } uil_src_t;

endpackage : uil_pkg

// ==== rtl/uil_top.sv ====
// Purpose: Prioritised interrupt identification and line format control of a serial port.
// Assumes: Event inputs are one-cycle pulses from the rest of the port.
// Notes: Register access over Avalon-MM with one wait cycle per access.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`include "uil_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module uil_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire uil_pkg::uil_ev_t EVENTS,
    input wire logic XON_SEEN,
    input wire logic FIFO_EN,
    input wire logic TX_SERIAL_IN,
    output logic TX_SERIAL_OUT,
    input wire logic [7:0] TX_DATA,
    output logic TX_PARITY,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_PARITY_IN,
    output logic RX_PARITY_ERR,
    output uil_pkg::uil_fmt_t FORMAT,
    output logic [3:0] DATA_BITS,
    output logic [2:0] STOP_HALVES,
    output logic [15:0] DIVISOR,
    output logic IRQ_ACTIVE
);

    logic ack;
    logic rd_go;
    logic wr_go;
    logic cap;
    uil_pkg::uil_fmt_t line;
    logic [7:0] enhanced_feature_reg;
    logic enh;
    logic [`UIL_NSRC-1:0] flag;
    logic [`UIL_NSRC-1:0] set_v;
    logic [`UIL_NSRC-1:0] clr_v;
    logic [`UIL_NSRC-1:0] ev_v;
    uil_pkg::uil_src_t cur;
    uil_pkg::uil_src_t next_cur;
    uil_pkg::uil_src_t rep;
    logic [7:0] pick;
    logic [5:0] id_code;
    logic [7:0] ident;
    logic [7:0] rd_byte;
    logic [7:0] tx_mask;
    logic [7:0] rx_mask;

    // A one-cycle wait lets read data come from a flop and keeps the
    // read-clear tied to the same edge at which the master takes the data.
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
    assign rd_go = AVS_READ & ack;
    assign wr_go = AVS_WRITE & ack;
    assign cap = AVS_READ & ~ack;
    assign enh = enhanced_feature_reg[`UIL_EFR_ENH_BIT];

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ack <= 1'b0;
        else
            ack <= (AVS_READ | AVS_WRITE) & ~ack;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            line <= `UIL_LINE_RST;
        end
        else if (wr_go && AVS_ADDRESS == `UIL_OFS_LINE)
        begin
            line <= AVS_WRITEDATA[7:0];
        end
    end

    // Divisor and enhanced features sit behind the latch-access bit.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            DIVISOR <= `UIL_DIV_RST;
            enhanced_feature_reg <= `UIL_EFR_RST;
        end
        else if (wr_go && line.dlab)
        begin
            if (AVS_ADDRESS == `UIL_OFS_DIV_LO)
                DIVISOR[7:0] <= AVS_WRITEDATA[7:0];
            if (AVS_ADDRESS == `UIL_OFS_DIV_HI)
                DIVISOR[15:8] <= AVS_WRITEDATA[7:0];
            if (AVS_ADDRESS == `UIL_OFS_IDENT)
                enhanced_feature_reg <= AVS_WRITEDATA[7:0];
        end
    end

    assign ev_v = EVENTS;

    // Flow and Xoff sources only latch while enhanced mode is on, so they
    // cannot surprise software that never enabled them.
    generate
        for (genvar i = 0; i < `UIL_NSRC; i++)
        begin : g_flag
            if (i == `UIL_SRC_XOFF || i == `UIL_SRC_FLOW)
            begin : g_enh
                assign set_v[i] = ev_v[i] & enh;
            end
            else
            begin : g_std
                assign set_v[i] = ev_v[i];
            end
            if (i == `UIL_SRC_XOFF)
            begin : g_xoff
                assign clr_v[i] = XON_SEEN;
            end
            else
            begin : g_rc
                assign clr_v[i] = rd_go && AVS_ADDRESS == `UIL_OFS_IDENT
                                  && !line.dlab && rep[i+1];
            end
            // A new event in the clearing cycle survives.
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                    flag[i] <= 1'b0;
                else
                    flag[i] <= set_v[i] | (flag[i] & ~clr_v[i]);
            end
        end
    endgenerate

    always_comb
    begin
        pick = uil_pkg::S_NONE;
        for (int i = `UIL_NSRC - 1; i >= 0; i--)
        begin
            if (flag[i])
                pick = 8'(9'h002 << i);
        end
    end

    always_comb
    begin
        next_cur = cur;
        if (cur == uil_pkg::S_NONE)
            next_cur = uil_pkg::uil_src_t'(pick);
        else if ((cur[7:1] & flag) == 7'h00)
            next_cur = uil_pkg::S_NONE;
    end

    // The reported source is frozen until its flag goes, even if a
    // higher one arrives meanwhile.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            cur <= uil_pkg::S_NONE;
        else
            cur <= next_cur;
    end

    always_comb
    begin
        case (cur)
            uil_pkg::S_LINE: id_code = `UIL_ID_LINE;
            uil_pkg::S_RXDATA: id_code = `UIL_ID_RXDATA;
            uil_pkg::S_TIMEOUT: id_code = `UIL_ID_TIMEOUT;
            uil_pkg::S_THRE: id_code = `UIL_ID_THRE;
            uil_pkg::S_MODEM: id_code = `UIL_ID_MODEM;
            uil_pkg::S_XOFF: id_code = `UIL_ID_XOFF;
            uil_pkg::S_FLOW: id_code = `UIL_ID_FLOW;
            default: id_code = `UIL_ID_NONE;
        endcase
    end

    assign ident = {{2{FIFO_EN}}, id_code};

    always_comb
    begin
        rd_byte = 8'h00;
        case (AVS_ADDRESS)
            `UIL_OFS_DIV_LO: rd_byte = line.dlab ? DIVISOR[7:0] : 8'h00;
            `UIL_OFS_DIV_HI: rd_byte = line.dlab ? DIVISOR[15:8] : 8'h00;
            `UIL_OFS_IDENT: rd_byte = line.dlab ? enhanced_feature_reg : ident;
            `UIL_OFS_LINE: rd_byte = line;
            default: rd_byte = 8'h00;
        endcase
    end

    // The snapshot of the reported source decides what the read clears.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            AVS_READDATA <= 32'h00000000;
            rep <= uil_pkg::S_NONE;
        end
        else if (cap)
        begin
            AVS_READDATA <= {24'h000000, rd_byte};
            rep <= (AVS_ADDRESS == `UIL_OFS_IDENT && !line.dlab) ? cur : uil_pkg::S_NONE;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            IRQ_ACTIVE <= 1'b0;
        else
            IRQ_ACTIVE <= (next_cur != uil_pkg::S_NONE);
    end

    assign FORMAT = line;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            TX_SERIAL_OUT <= 1'b1;
        else
            TX_SERIAL_OUT <= TX_SERIAL_IN & ~line.brk;
    end

    always_comb
    begin
        DATA_BITS = `UIL_WLEN_BASE + {2'b00, line.wlen};
        if (!line.stop_long)
            STOP_HALVES = `UIL_STOP_ONE;
        else if (line.wlen == `UIL_WLEN_FIVE)
            STOP_HALVES = `UIL_STOP_ONE_HALF;
        else
            STOP_HALVES = `UIL_STOP_TWO;
    end

    // Only the bits of the selected character length take part.
    assign tx_mask = TX_DATA & (8'hFF >> (3'h3 - {1'b0, line.wlen}));
    assign rx_mask = RX_DATA & (8'hFF >> (3'h3 - {1'b0, line.wlen}));

    function automatic logic par_bit(input logic [7:0] d, input uil_pkg::uil_fmt_t f);
        if (f.stick)
            par_bit = ~f.even;
        else
            par_bit = ^d ^ ~f.even;
    endfunction : par_bit

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            TX_PARITY <= 1'b0;
            RX_PARITY_ERR <= 1'b0;
        end
        else
        begin
            TX_PARITY <= line.par_en & par_bit(tx_mask, line);
            RX_PARITY_ERR <= line.par_en & (par_bit(rx_mask, line) ^ RX_PARITY_IN);
        end
    end

endmodule : uil_top

`default_nettype wire

// ==== test/uil_top_chk.sv ====
// Purpose: Port assertions for uil_top.
// Assumes: The host leaves the bus idle for a cycle between requests.
// Notes: Attached to every uil_top by bind.
`timescale 1ns/1ps
`default_nettype none
module uil_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic TX_SERIAL_OUT,
    input wire logic TX_PARITY,
    input wire logic RX_PARITY_IN,
    input wire logic RX_PARITY_ERR,
    input wire uil_pkg::uil_fmt_t FORMAT,
    input wire logic [3:0] DATA_BITS,
    input wire logic [2:0] STOP_HALVES,
    input wire logic [15:0] DIVISOR
);
    // Registered outputs follow the format of one cycle earlier.
    uil_pkg::uil_fmt_t fmt_q;
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            fmt_q <= '0;
        else
            fmt_q <= FORMAT;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_acc;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    property p_acc;
        $rose(AVS_READ || AVS_WRITE) |-> s_acc;
    endproperty
    property p_brk;
        FORMAT.brk && fmt_q.brk |-> !TX_SERIAL_OUT;
    endproperty
    property p_len;
        DATA_BITS == 4'h5 + {2'h0, FORMAT.wlen};
    endproperty
    property p_stop;
        STOP_HALVES == (!FORMAT.stop_long ? 3'h2 : (FORMAT.wlen == 2'h0 ? 3'h3 : 3'h4));
    endproperty
    property p_nopar;
        !fmt_q.par_en |-> !TX_PARITY && !RX_PARITY_ERR;
    endproperty
    property p_stick;
        fmt_q.par_en && fmt_q.stick |-> TX_PARITY == !fmt_q.even;
    endproperty
    property p_rxstick;
        fmt_q.par_en && fmt_q.stick |-> RX_PARITY_ERR == ($past(RX_PARITY_IN) == fmt_q.even);
    endproperty
    property p_div;
        !FORMAT.dlab |=> $stable(DIVISOR);
    endproperty
    a_acc: assert property (p_acc) else $error("access not answered in one wait");
    a_brk: assert property (p_brk) else $error("break not driving line low");
    a_len: assert property (p_len) else $error("data bit count wrong");
    a_stop: assert property (p_stop) else $error("stop length wrong");
    a_nopar: assert property (p_nopar) else $error("parity active while off");
    a_stick: assert property (p_stick) else $error("forced tx parity wrong");
    a_rxstick: assert property (p_rxstick) else $error("forced rx check wrong");
    a_div: assert property (p_div) else $error("divisor changed while hidden");
endmodule : uil_chk
bind uil_top uil_chk u_chk (.CLK(CLK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_SERIAL_OUT(TX_SERIAL_OUT), .TX_PARITY(TX_PARITY),
    .RX_PARITY_IN(RX_PARITY_IN), .RX_PARITY_ERR(RX_PARITY_ERR), .FORMAT(FORMAT),
    .DATA_BITS(DATA_BITS), .STOP_HALVES(STOP_HALVES), .DIVISOR(DIVISOR));
`default_nettype wire

// ==== test/uil_host.sv ====
// Purpose: Avalon-MM host that reaches the block's registers.
// Assumes: The slave holds waitrequest high until it answers.
// Notes: Released address and data are inverted so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module uil_host (
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [3:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata
);
    initial
    begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        address <= ~a;
        writedata <= ~{24'h0, d};
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        address <= ~a;
    endtask : rd
endmodule : uil_host
`default_nettype wire

// ==== test/test_uil_irq_ident_line_format.sv ====
// Purpose: Self-checking bench for uil_top.
// Assumes: Sources are pulsed one cycle; the host speaks Avalon-MM.
// Notes: Transmit and receive data hold three ones.
`timescale 1ns/1ps
`default_nettype none
module test_uil_irq_ident_line_format;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] adr;
    logic rd_s, wr_s, wreq, xon, fen, txo, txp, rxp, rxe, irq;
    logic [31:0] wdat, rdat, d;
    logic [15:0] div;
    uil_pkg::uil_ev_t evs;
    uil_pkg::uil_fmt_t fmt;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] pri [6] = '{8'h06, 8'h04, 8'h0C, 8'h02, 8'h00, 8'h01};
    logic [7:0] fl [6] = '{8'h04, 8'h0D, 8'h1A, 8'h2B, 8'h3B, 8'h03};
    logic fp [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    always #20 clk = ~clk;
    uil_host host (.clk(clk), .waitrequest(wreq), .readdata(rdat), .address(adr), .read(rd_s),
        .write(wr_s), .writedata(wdat));
    uil_top DUT (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
        .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .EVENTS(evs),
        .XON_SEEN(xon), .FIFO_EN(fen), .TX_SERIAL_IN(1'b1), .TX_SERIAL_OUT(txo),
        .TX_DATA(8'h07), .TX_PARITY(txp), .RX_DATA(8'h07), .RX_PARITY_IN(rxp),
        .RX_PARITY_ERR(rxe), .FORMAT(fmt), .DATA_BITS(), .STOP_HALVES(), .DIVISOR(div),
        .IRQ_ACTIVE(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic ev(input uil_pkg::uil_ev_t e);
        @(posedge clk);
        evs <= e;
        @(posedge clk);
        evs <= '0;
    endtask : ev
    // Three idle edges let a cleared source make way for the next one.
    task automatic idt(input logic [7:0] exp);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, {31'h0, ~exp[0]});
        host.rd(4'h8, d);
        chk(d, {24'h0, exp});
    endtask : idt
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    initial
    begin
        evs = '0;
        xon = 1'b0;
        fen = 1'b0;
        rxp = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        idt(8'h01);
        host.rd(4'hC, d);
        chk(d, 32'h0);
        ev(7'h1F);
        foreach (pri[i]) idt(pri[i]);
        ev(7'h08);
        ev(7'h01);
        idt(8'h02);
        idt(8'h06);
        ev(7'h60);
        idt(8'h01);
        for (int i = 0; i < 6; i++)
        begin
            rxp <= ~fp[i];
            host.wr(4'hC, fl[i]);
            repeat (2) @(posedge clk);
            chk({31'h0, txp}, {31'h0, fp[i]});
            chk({31'h0, rxe}, {31'h0, fl[i][3]});
            host.rd(4'hC, d);
            chk(d, {24'h0, fl[i]});
        end
        host.wr(4'hC, 8'h40);
        repeat (2) @(posedge clk);
        chk({31'h0, txo}, 32'h0);
        host.wr(4'hC, 8'h80);
        repeat (2) @(posedge clk);
        chk({31'h0, txo}, 32'h1);
        host.wr(4'h0, 8'h34);
        host.wr(4'h4, 8'h12);
        host.wr(4'h8, 8'h10);
        host.wr(4'hC, 8'h00);
        chk({16'h0, div}, 32'h1234);
        host.rd(4'h0, d);
        chk(d, 32'h0);
        host.wr(4'h0, 8'h55);
        chk({16'h0, div}, 32'h1234);
        fen <= 1'b1;
        ev(7'h20);
        idt(8'hD0);
        idt(8'hD0);
        @(posedge clk);
        xon <= 1'b1;
        @(posedge clk);
        xon <= 1'b0;
        idt(8'hC1);
        ev(7'h40);
        idt(8'hE0);
        idt(8'hC1);
        give_verdict();
    end
endmodule : test_uil_irq_ident_line_format
`default_nettype wire
